// ---- common/cps_pkg.sv ----
package cps_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte offsets
   localparam logic [7:0] CPS_CMD_OFS   = 8'h00;
   localparam logic [7:0] CPS_STAT_OFS  = 8'h04;
   localparam logic [7:0] CPS_SRC_OFS   = 8'h08;
   localparam logic [1:0] CPS_WIN_CTRL  = 2'h1;  // 0x40: controller tags / working copy
   localparam logic [1:0] CPS_WIN_WEB   = 2'h2;  // 0x80: web server / nv copy
   localparam logic [1:0] CPS_WIN_ASM   = 2'h3;  // 0xC0: config assembly / factory image

   // command register fields
   localparam int CPS_CMD_SVC_LSB = 0;
   localparam int CPS_CMD_CLS_LSB = 8;
   localparam int CPS_CMD_DAT_LSB = 16;

   // class services
   localparam logic [7:0] CPS_SVC_RESET   = 8'h05;
   localparam logic [7:0] CPS_SVC_RESTORE = 8'h15;
   localparam logic [7:0] CPS_SVC_SAVE    = 8'h16;
   localparam logic [7:0] CPS_CLASS_POS   = 8'h23;
   localparam logic [7:0] CPS_RESET_DATA  = 8'h01;

   // local factory-reset gesture
   localparam logic [11:0] CPS_SW_FRESET  = 12'h0888;
   localparam int          CPS_HOLD_S     = 5;
   localparam int          CPS_CLK_HZ     = 20_000_000;
   localparam int          CPS_HOLD_CYC   = CPS_HOLD_S * CPS_CLK_HZ;

   // integration modes
   localparam logic [1:0] CPS_INT_GENERIC = 2'h0;
   localparam logic [1:0] CPS_INT_EDS     = 2'h1;
   localparam logic [1:0] CPS_INT_LADDER  = 2'h2;

   // parameter set: which entries a factory reset or save touches, which sit in the assembly
   localparam int          CPS_NPARAM     = 16;
   localparam logic [15:0] CPS_RESET_MASK = 16'h1fff;
   localparam logic [15:0] CPS_ASM_MASK   = 16'h07ff;
   localparam logic [31:0] CPS_FACTORY [16] = '{
      32'h0000_0000, 32'h0000_0000, 32'h0004_0000, 32'h4000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h3fff_ffff, 32'hffff_d120,
      32'h0000_2ee0, 32'h0000_0800, 32'h0000_0001, 32'h2598_0600,
      32'h000f_4240, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

   typedef enum logic [2:0] {OP_IDLE, OP_LOAD, OP_RESTORE, OP_SAVE, OP_FRESET, OP_APPLY} cps_op_t;

   // configuration source settings, low five bits of the source register
   typedef struct packed {
      logic       online;
      logic       ws_inst;
      logic [1:0] integ;
      logic       asm_en;
   } cps_src_t;

endpackage : cps_pkg

// ---- verilog/cps_store.sv ----
// Contract
// - operating parameters always come from the working copy
// - modifications land in the working copy; only save makes them persistent
// - at power-on the whole set is copied from nv into working copy
// - a fixed factory image exists and feeds factory reset
// - switches at 888 plus pushbutton held over 5 s triggers factory reset
// - service 05h, class 23h, data 01h resets resettable parameters to factory
// - service 15h reloads working copy from nv, dropping unsaved changes
// - service 16h copies savable parameters from working copy into nv
// - active assembly values win over earlier web server values
// - without assembly, web server may configure every parameter
// - instances 101-103: controller tags configure; web only outside assembly
// - server-configured instance variants: web server configures parameters
// - generic/description-file writes staged offline, applied on going online
// - mapping routine changes apply at once, also online
// - web changes take effect immediately; controller changes only under mapping routine or while online
// - factory reset keeps motion time, operating time, temperature limits, max voltage
`timescale 1ns/1ps
module cps_store
   import cps_pkg::*;
#(
   parameter int NPARAM      = CPS_NPARAM,
   parameter int HOLD_CYCLES = CPS_HOLD_CYC
) (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic      [31:0]              hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   input  wire logic [11:0]              addr_switch,
   input  wire logic                     preset_btn,
   output logic                          op_busy,
   output logic      [NPARAM-1:0][31:0]  param_out
);

   if (NPARAM < 1 || NPARAM > CPS_NPARAM || HOLD_CYCLES < 1) begin : g_bad_param
      $error("cps_store: NPARAM must be 1..16 and HOLD_CYCLES at least 1");
   end

   typedef struct packed {
      logic [NPARAM-1:0][31:0] work;
      logic [NPARAM-1:0][31:0] nv;
      logic [NPARAM-1:0][31:0] stage;
      logic [NPARAM-1:0]       stg_vld;
      cps_op_t                 op;
      logic [3:0]              idx;
      logic                    pend;
      logic                    hw;
      logic [7:0]              ha;
      logic                    rdy;
      logic                    resp;
      logic [31:0]             rdata;
      cps_src_t                src;
      logic                    online_q;
      logic                    apply_req;
      logic [31:0]             hold_cnt;
      logic                    fired;
      logic                    btn_req;
      logic                    refused;
      logic                    bad_svc;
      logic [7:0]              last_svc;
      logic                    busy;
   } cps_state_t;

   cps_state_t s_ff;
   cps_state_t nxt_s;

   ////////////////////////////////////////////////////////////////////////////
   // write routing: returns {accept, staged} for a source writing one entry
   function automatic logic [1:0] cps_route(cps_src_t src, logic [1:0] win, logic in_asm);
      logic asm_owns;
      logic acc;
      logic stg;
      asm_owns = (src.integ == CPS_INT_GENERIC && src.asm_en) ||
                 (src.integ == CPS_INT_EDS && !src.ws_inst);
      acc = 1'b0;
      stg = 1'b0;
      case (win)
         CPS_WIN_WEB: begin
            acc = !(asm_owns && in_asm);
         end
         CPS_WIN_CTRL: begin
            acc = src.integ == CPS_INT_LADDER || (src.integ == CPS_INT_EDS && !src.ws_inst);
            stg = src.integ != CPS_INT_LADDER && !src.online;
         end
         CPS_WIN_ASM: begin
            acc = asm_owns;
            stg = !src.online;
         end
         default: begin
            acc = 1'b0;
         end
      endcase
      return {acc, stg};
   endfunction : cps_route

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [3:0]  wi;
      logic [1:0]  rt;
      logic        svc_go;
      logic [7:0]  svc;
      logic [7:0]  cls;
      logic [7:0]  dat;
      nxt_s  = s_ff;
      wi     = s_ff.ha[5:2];
      rt     = cps_route(s_ff.src, s_ff.ha[7:6], CPS_ASM_MASK[wi]);
      svc_go = 1'b0;
      svc    = hwdata[CPS_CMD_SVC_LSB +: 8];
      cls    = hwdata[CPS_CMD_CLS_LSB +: 8];
      dat    = hwdata[CPS_CMD_DAT_LSB +: 8];

      // engine: one entry per cycle, bus writes stall meanwhile so each op is atomic
      if (s_ff.op != OP_IDLE) begin
         case (s_ff.op)
            OP_LOAD, OP_RESTORE: nxt_s.work[s_ff.idx] = s_ff.nv[s_ff.idx];
            OP_SAVE: begin
               if (CPS_RESET_MASK[s_ff.idx]) begin
                  nxt_s.nv[s_ff.idx] = s_ff.work[s_ff.idx];
               end
            end
            OP_FRESET: begin
               if (CPS_RESET_MASK[s_ff.idx]) begin
                  nxt_s.work[s_ff.idx] = CPS_FACTORY[s_ff.idx];
               end
            end
            OP_APPLY: begin
               if (s_ff.stg_vld[s_ff.idx]) begin
                  nxt_s.work[s_ff.idx]    = s_ff.stage[s_ff.idx];
                  nxt_s.stg_vld[s_ff.idx] = 1'b0;
               end
            end
            default: nxt_s.op = OP_IDLE;
         endcase
         if (s_ff.idx == 4'(NPARAM - 1)) begin
            nxt_s.op  = OP_IDLE;
            nxt_s.idx = 4'h0;
         end else begin
            nxt_s.idx = s_ff.idx + 4'h1;
         end
      end

      // bus data phase, one wait state; writes wait while the engine runs
      if (s_ff.pend) begin
         if (!s_ff.hw) begin
            nxt_s.pend  = 1'b0;
            nxt_s.rdy   = 1'b1;
            nxt_s.rdata = 32'h0000_0000;
            if (s_ff.ha[7:6] != 2'h0) begin
               if (32'(wi) < NPARAM) begin
                  case (s_ff.ha[7:6])
                     CPS_WIN_CTRL: nxt_s.rdata = s_ff.work[wi];
                     CPS_WIN_WEB:  nxt_s.rdata = s_ff.nv[wi];
                     default:      nxt_s.rdata = CPS_FACTORY[wi];
                  endcase
               end
            end else if (s_ff.ha == CPS_STAT_OFS) begin
               nxt_s.rdata = {16'h0000, s_ff.last_svc, 4'h0, s_ff.bad_svc, s_ff.refused,
                              s_ff.apply_req, s_ff.op != OP_IDLE};
            end else if (s_ff.ha == CPS_SRC_OFS) begin
               nxt_s.rdata = {27'h000_0000, s_ff.src};
            end
         end else if (s_ff.op == OP_IDLE) begin
            nxt_s.pend = 1'b0;
            nxt_s.rdy  = 1'b1;
            if (s_ff.ha[7:6] != 2'h0) begin
               if (32'(wi) < NPARAM) begin
                  nxt_s.refused = !rt[1];
                  if (rt[1] && rt[0]) begin
                     nxt_s.stage[wi]   = hwdata;
                     nxt_s.stg_vld[wi] = 1'b1;
                  end else if (rt[1]) begin
                     nxt_s.work[wi] = hwdata;
                  end
               end
            end else if (s_ff.ha == CPS_CMD_OFS) begin
               svc_go         = 1'b1;
               nxt_s.last_svc = svc;
               nxt_s.bad_svc  = 1'b0;
               nxt_s.idx      = 4'h0;
               if (cls != CPS_CLASS_POS) begin
                  nxt_s.bad_svc = 1'b1;
               end else if (svc == CPS_SVC_RESET && dat == CPS_RESET_DATA) begin
                  nxt_s.op = OP_FRESET;
               end else if (svc == CPS_SVC_RESTORE) begin
                  nxt_s.op = OP_RESTORE;
               end else if (svc == CPS_SVC_SAVE) begin
                  nxt_s.op = OP_SAVE;
               end else begin
                  nxt_s.bad_svc = 1'b1;
               end
            end else if (s_ff.ha == CPS_SRC_OFS) begin
               nxt_s.src = hwdata[4:0];
            end
         end
      end

      // address phase accepted only while this slave is ready
      if (hsel && hready && htrans[1] && hsize == 3'h2) begin
         nxt_s.pend = 1'b1;
         nxt_s.rdy  = 1'b0;
         nxt_s.hw   = hwrite;
         nxt_s.ha   = {haddr[7:2], 2'h0};
      end

      // going online releases staged offline configuration
      nxt_s.online_q = s_ff.src.online;
      if (s_ff.src.online && !s_ff.online_q && s_ff.stg_vld != '0) begin
         nxt_s.apply_req = 1'b1;
      end

      // pushbutton hold; counter saturates so a long hold fires once
      if (addr_switch == CPS_SW_FRESET && preset_btn) begin
         if (s_ff.hold_cnt < 32'(HOLD_CYCLES)) begin
            nxt_s.hold_cnt = s_ff.hold_cnt + 32'h0000_0001;
         end else if (!s_ff.fired) begin
            nxt_s.fired   = 1'b1;
            nxt_s.btn_req = 1'b1;
         end
      end else begin
         nxt_s.hold_cnt = 32'h0000_0000;
         nxt_s.fired    = 1'b0;
      end

      // pending local requests start only when the engine and the bus leave it free
      if (s_ff.op == OP_IDLE && !svc_go) begin
         if (s_ff.btn_req) begin
            nxt_s.op      = OP_FRESET;
            nxt_s.idx     = 4'h0;
            nxt_s.btn_req = 1'b0;
         end else if (s_ff.apply_req) begin
            nxt_s.op        = OP_APPLY;
            nxt_s.idx       = 4'h0;
            nxt_s.apply_req = 1'b0;
         end
      end

      // busy kept as its own flop so op_busy leaves the block without decode logic
      nxt_s.busy = nxt_s.op != OP_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; nv powers up holding the factory image
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff     <= '0;
         s_ff.op  <= OP_LOAD;
         s_ff.rdy <= 1'b1;
         s_ff.busy <= 1'b1;
         for (int i = 0; i < NPARAM; i++) begin
            s_ff.nv[i] <= CPS_FACTORY[i];
         end
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from the state flops
   assign hrdata    = s_ff.rdata;
   assign hreadyout = s_ff.rdy;
   assign hresp     = s_ff.resp;
   assign op_busy   = s_ff.busy;
   assign param_out = s_ff.work;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [31:0] cur_nv;
   logic [31:0] cur_work;
   logic        web_wr_now;
   assign cur_nv     = s_ff.nv[s_ff.idx];
   assign cur_work   = s_ff.work[s_ff.idx];
   assign web_wr_now = s_ff.pend && s_ff.hw && s_ff.op == OP_IDLE && s_ff.ha[7:6] == CPS_WIN_WEB &&
                       32'(s_ff.ha[5:2]) < NPARAM;

   // staged writes, apply source and command writes seen by the checks below
   logic [31:0] cur_stage;
   logic        stg_wr_now;
   logic        cmd_wr_now;
   assign cur_stage  = s_ff.stage[s_ff.idx];
   assign stg_wr_now = s_ff.pend && s_ff.hw && s_ff.op == OP_IDLE && s_ff.ha[7:6] != 2'h0 &&
                       32'(s_ff.ha[5:2]) < NPARAM &&
                       cps_route(s_ff.src, s_ff.ha[7:6], CPS_ASM_MASK[s_ff.ha[5:2]]) == 2'b11;
   assign cmd_wr_now = s_ff.pend && s_ff.hw && s_ff.op == OP_IDLE && s_ff.ha == CPS_CMD_OFS;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_power_on_load: assert property (
      s_ff.op == OP_LOAD |=> s_ff.work[$past(s_ff.idx)] == $past(cur_nv))
      else $error("power-on load did not copy nv entry");
   chk_restore_copy: assert property (
      s_ff.op == OP_RESTORE |=> s_ff.work[$past(s_ff.idx)] == $past(cur_nv))
      else $error("restore did not reload entry from nv");
   chk_save_copy: assert property (
      s_ff.op == OP_SAVE && CPS_RESET_MASK[s_ff.idx] |=> s_ff.nv[$past(s_ff.idx)] == $past(cur_work))
      else $error("save did not store working entry");
   chk_freset_value: assert property (
      s_ff.op == OP_FRESET && CPS_RESET_MASK[s_ff.idx]
      |=> s_ff.work[$past(s_ff.idx)] == CPS_FACTORY[$past(s_ff.idx)])
      else $error("factory reset wrote wrong value");
   chk_freset_keeps: assert property (
      s_ff.op == OP_FRESET && !CPS_RESET_MASK[s_ff.idx] |=> s_ff.work[$past(s_ff.idx)] == $past(cur_work))
      else $error("factory reset touched a preserved entry");
   chk_write_stall: assert property (
      s_ff.pend && s_ff.hw && s_ff.op != OP_IDLE |=> !hreadyout)
      else $error("write completed during an atomic operation");
   chk_web_immediate: assert property (
      web_wr_now && cps_route(s_ff.src, CPS_WIN_WEB, CPS_ASM_MASK[s_ff.ha[5:2]]) == 2'b10
      |=> s_ff.work[$past(s_ff.ha[5:2])] == $past(hwdata) && hreadyout)
      else $error("web write not applied at once");
   chk_web_blocked: assert property (
      web_wr_now && cps_route(s_ff.src, CPS_WIN_WEB, CPS_ASM_MASK[s_ff.ha[5:2]]) == 2'b00
      |=> $stable(s_ff.work) && s_ff.refused)
      else $error("web write overrode an assembly parameter");
   chk_button_hold: assert property (
      addr_switch == CPS_SW_FRESET && preset_btn && s_ff.hold_cnt == 32'(HOLD_CYCLES) && !s_ff.fired
      |=> s_ff.btn_req ##[1:20] s_ff.op == OP_FRESET)
      else $error("held pushbutton did not start factory reset");
   chk_online_apply: assert property (
      $rose(s_ff.apply_req) |-> ##[1:40] s_ff.op == OP_APPLY)
      else $error("staged configuration not applied after going online");
   chk_stage_hold: assert property (
      stg_wr_now |=> s_ff.stg_vld[$past(s_ff.ha[5:2])] && s_ff.stage[$past(s_ff.ha[5:2])] == $past(hwdata) &&
                     $stable(s_ff.work))
      else $error("offline write reached the working copy");
   chk_apply_copy: assert property (
      s_ff.op == OP_APPLY && s_ff.stg_vld[s_ff.idx] |=> s_ff.work[$past(s_ff.idx)] == $past(cur_stage))
      else $error("going online did not apply a staged entry");
   chk_reset_data: assert property (
      cmd_wr_now && hwdata[CPS_CMD_SVC_LSB +: 8] == CPS_SVC_RESET && hwdata[CPS_CMD_DAT_LSB +: 8] != CPS_RESET_DATA
      |=> s_ff.op == OP_IDLE && s_ff.bad_svc)
      else $error("reset service with wrong data started an operation");

   cov_save:    cover property (s_ff.op == OP_IDLE ##1 s_ff.op == OP_SAVE);
   cov_restore: cover property (s_ff.op == OP_IDLE ##1 s_ff.op == OP_RESTORE);
   cov_freset:  cover property (s_ff.btn_req ##1 s_ff.op == OP_FRESET);
   cov_apply:   cover property (s_ff.op == OP_APPLY && s_ff.stg_vld[s_ff.idx]);
   cov_stall:   cover property (s_ff.pend && s_ff.hw && s_ff.op != OP_IDLE);

endmodule : cps_store

// ---- bench/cps_ctrl_model.sv ----
`timescale 1ns/1ps
// network controller side: a single-master bus agent issuing word transfers
module cps_ctrl_model
   import cps_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   // idle bus at time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'b010;
      hwdata = 32'h0000_0000;
   end

   // one transfer; hready is sampled at the rising edge, before the slave's flops move
   task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
      while (hresetn !== 1'b1) @(posedge hclk);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, ofs};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      // released data lines carry the inverse, not a stale copy
      hwdata <= ~wd;
      haddr  <= ~{24'h00_0000, ofs};
   endtask : xfer
endmodule : cps_ctrl_model

// ---- bench/cps_store_tb.sv ----
`timescale 1ns/1ps
module cps_store_tb;
   import cps_pkg::*;
   localparam int HOLD = 20;   // short hold so the gesture fits the run
   logic                        hclk, hresetn, hsel, hwrite, hreadyout, hresp, op_busy, preset_btn;
   logic [31:0]                 haddr, hwdata, hrdata;
   logic [1:0]                  htrans;
   logic [2:0]                  hsize;
   logic [11:0]                 addr_switch;
   logic [CPS_NPARAM-1:0][31:0] param_out;
   int                          miscompares = 0;
   int                          num_checks  = 0;

   cps_store #(.NPARAM(CPS_NPARAM), .HOLD_CYCLES(HOLD)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .addr_switch(addr_switch),
      .preset_btn(preset_btn), .op_busy(op_busy), .param_out(param_out));
   cps_ctrl_model u_ctrl (.hclk(hclk), .hresetn(hresetn), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   initial hclk = 1'b0;
   always #25 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      logic [31:0] r;
      u_ctrl.xfer(1'b1, ofs, d, r);
   endtask : wr
   task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [31:0] msk, input logic [31:0] exp);
      logic [31:0] r;
      u_ctrl.xfer(1'b0, ofs, 32'h0000_0000, r);
      check(what, exp & msk, r & msk);
   endtask : rd_chk
   // bounded wait, the engine runs one entry per cycle
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge hclk);
      while (op_busy !== 1'b0 && n < 200) begin
         @(negedge hclk);
         n++;
      end
      check("op_busy", 32'h0000_0000, {31'h0, op_busy});
   endtask : wait_idle
   task automatic chk_par(input int i, input logic [31:0] exp);
      @(negedge hclk);
      check("param_out", exp, param_out[i]);
   endtask : chk_par
   task automatic service(input logic [7:0] svc, input logic [7:0] dat);
      wr(CPS_CMD_OFS, {8'h00, dat, CPS_CLASS_POS, svc});
      wait_idle();
   endtask : service
   task automatic wrap_up();
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_power_on();
      wait_idle();
      for (int i = 0; i < CPS_NPARAM; i++) check("param_out", CPS_FACTORY[i], param_out[i]);
      rd_chk("factory", 8'hC8, 32'hffff_ffff, CPS_FACTORY[2]);
      check("hresp", 32'h0000_0000, {31'h0, hresp});
   endtask : t_power_on
   task automatic t_save_restore();
      wr(CPS_SRC_OFS, 32'h0000_0000);
      wr(8'h88, 32'h0000_1234);
      chk_par(2, 32'h0000_1234);
      rd_chk("nv", 8'h88, 32'hffff_ffff, CPS_FACTORY[2]);
      rd_chk("working", 8'h48, 32'hffff_ffff, 32'h0000_1234);
      service(CPS_SVC_RESTORE, 8'h00);
      chk_par(2, CPS_FACTORY[2]);
      wr(8'h88, 32'h0000_1234);
      wr(8'hB4, 32'haaaa_0001);
      service(CPS_SVC_SAVE, 8'h00);
      rd_chk("nv", 8'h88, 32'hffff_ffff, 32'h0000_1234);
      rd_chk("nv", 8'hB4, 32'hffff_ffff, CPS_FACTORY[13]);
   endtask : t_save_restore
   task automatic t_factory_reset();
      wr(8'h8C, 32'h0000_5555);
      service(CPS_SVC_RESET, 8'h02);
      rd_chk("status", CPS_STAT_OFS, 32'h0000_0008, 32'h0000_0008);
      chk_par(3, 32'h0000_5555);
      service(CPS_SVC_RESET, CPS_RESET_DATA);
      chk_par(3, CPS_FACTORY[3]);
      chk_par(13, 32'haaaa_0001);
      rd_chk("nv", 8'h88, 32'hffff_ffff, 32'h0000_1234);
   endtask : t_factory_reset
   task automatic t_sources();
      wr(CPS_SRC_OFS, 32'h0000_0001);
      wr(8'h90, 32'h0000_0077);
      rd_chk("status", CPS_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
      wr(8'hD0, 32'h0000_0099);
      chk_par(4, CPS_FACTORY[4]);
      wr(CPS_SRC_OFS, 32'h0000_0011);
      repeat (4) @(posedge hclk);
      wait_idle();
      chk_par(4, 32'h0000_0099);
      wr(8'hB0, 32'h0000_0042);
      chk_par(12, 32'h0000_0042);
      wr(CPS_SRC_OFS, 32'h0000_0002);
      wr(8'h84, 32'h0000_0011);
      rd_chk("status", CPS_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
      chk_par(1, CPS_FACTORY[1]);
      wr(8'h44, 32'h0000_0033);
      chk_par(1, CPS_FACTORY[1]);
      wr(CPS_SRC_OFS, 32'h0000_0012);
      repeat (4) @(posedge hclk);
      wait_idle();
      chk_par(1, 32'h0000_0033);
      wr(CPS_SRC_OFS, 32'h0000_000A);
      wr(8'h84, 32'h0000_0022);
      chk_par(1, 32'h0000_0022);
      wr(CPS_SRC_OFS, 32'h0000_0004);
      wr(8'h48, 32'h0000_0321);
      chk_par(2, 32'h0000_0321);
   endtask : t_sources
   // a save in flight holds a later write until it is done
   task automatic t_atomic();
      wr(8'h8C, 32'h0000_5a5a);
      wr(CPS_CMD_OFS, {8'h00, 8'h00, CPS_CLASS_POS, CPS_SVC_SAVE});
      wr(8'h8C, 32'h0000_6666);
      @(negedge hclk);
      check("op_busy", 32'h0000_0000, {31'h0, op_busy});
      chk_par(3, 32'h0000_6666);
      rd_chk("nv", 8'h8C, 32'hffff_ffff, 32'h0000_5a5a);
   endtask : t_atomic
   // wrong switch, short press, then the real gesture
   task automatic t_button();
      logic [11:0] sw [3] = '{12'h0887, 12'h0888, 12'h0888};
      int          len [3] = '{HOLD + 6, HOLD - 4, HOLD + 4};
      for (int k = 0; k < 3; k++) begin
         @(posedge hclk);
         addr_switch <= sw[k];
         preset_btn  <= 1'b1;
         repeat (len[k]) @(posedge hclk);
         preset_btn  <= 1'b0;
         wait_idle();
         chk_par(3, (k == 2) ? CPS_FACTORY[3] : 32'h0000_6666);
      end
   endtask : t_button

   ////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      hresetn     = 1'b0;
      preset_btn  = 1'b0;
      addr_switch = 12'h0000;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_power_on();
      t_save_restore();
      t_factory_reset();
      t_sources();
      t_atomic();
      t_button();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge hclk);
      miscompares++;
      wrap_up();
   end
endmodule : cps_store_tb
